// >>> verilog/lird_defines.vh
// constants of the legacy compatible idle, repeat and bit-op decoder
// Operation
// - idle stops fetch and execution until an unmasked interrupt arrives
// - idle leaves the global interrupt mask bit untouched
// - wake with mask set resumes at the word after idle, no vector
// - wake with mask clear vectors, services the interrupt, then resumes
// - second idle halts likewise but only an external interrupt ends it
// - repeat counter is 16 bits, memory count gives up to 65536 runs
// - repeat with 16-bit immediate is two words; decoder fetches the count
// - serial mode bits live only in the serial control register
// - frame format is bit 2, sync mode bit 3, transmit mode bit 5
// - or-op sets, and-op clears any mix of bits; others stay unchanged
// - xor-op toggles selected serial control bits in one read-modify-write
// - one add covers short immediate, long immediate and high-half memory
// - every legacy operation maps to a native instruction or format
// - normalize updates its aux register late, on the pointer then current
// - a discontinuity takes four cycles, a delayed one takes two
`ifndef LIRD_DEFINES_VH
`define LIRD_DEFINES_VH
// -----------------------------------------------------------------
// opcode field ir[15:12]
// -----------------------------------------------------------------
`define LIRD_OP_NOP      4'h0
`define LIRD_OP_IDLE     4'h1
`define LIRD_OP_HALT_UNTIL_EXTERNAL_INT_OP    4'h2
`define LIRD_OP_RPT_K    4'h3
`define LIRD_OP_RPT_L    4'h4
`define LIRD_OP_RPT_M    4'h5
`define LIRD_OP_ADD_K    4'h6
`define LIRD_OP_ADD_L    4'h7
`define LIRD_OP_ADD_M    4'h8
`define LIRD_OP_OPL      4'h9
`define LIRD_OP_APL      4'hA
`define LIRD_OP_XPL      4'hB
`define LIRD_OP_LDP      4'hC
`define LIRD_OP_CONDITIONAL_BRANCH_OP     4'hD
`define LIRD_OP_CTRLBIT  4'hE
`define LIRD_OP_NORMALIZE_OP     4'hF
// -----------------------------------------------------------------
// instruction fields
// -----------------------------------------------------------------
`define LIRD_F_ALT       11
`define LIRD_F_SHIFT16   8
`define LIRD_F_SETBIT    8
`define LIRD_F_DELAYED   7
`define LIRD_CB_GIM      2'h0
`define LIRD_CB_OVM      2'h1
`define LIRD_CB_SXM      2'h2
`define LIRD_CB_CARRY    2'h3
`define LIRD_CC_ALWAYS   4'h0
`define LIRD_CC_EQ       4'h1
`define LIRD_CC_NEQ      4'h2
`define LIRD_CC_LT       4'h3
`define LIRD_CC_GT       4'h4
`define LIRD_CC_GEQ      4'h5
`define LIRD_CC_LEQ      4'h6
`define LIRD_CC_C        4'h7
`define LIRD_CC_NC       4'h8
// -----------------------------------------------------------------
// data space and serial control bits
// -----------------------------------------------------------------
`define LIRD_SPC_DADDR   7'h22
`define LIRD_DMEM_OFS    3'h6
`define LIRD_SPC_FMT     16'h0004
`define LIRD_SPC_FSM     16'h0008
`define LIRD_SPC_TXM     16'h0020
`define LIRD_SPC_RST     16'h0000
// -----------------------------------------------------------------
// flow control
// -----------------------------------------------------------------
`define LIRD_RESET_PC    16'h0000
`define LIRD_VEC_BASE    16'h0002
`define LIRD_DISC_FLUSH  2'h2
`define LIRD_DLY_FLUSH   2'h0
`define LIRD_NORMALIZE_OP_LAG    2'h2
// -----------------------------------------------------------------
// register offsets (word indexes matched against avs_address[5:2]) and status bits
// -----------------------------------------------------------------
`define LIRD_REG_CTRL    4'h0
`define LIRD_REG_IMR     4'h1
`define LIRD_REG_SPC     4'h2
`define LIRD_REG_STATUS  4'h3
`define LIRD_REG_PC      4'h4
`define LIRD_REG_RPT     4'h5
`define LIRD_REG_ACC_LO  4'h6
`define LIRD_REG_ACC_HI  4'h7
`define LIRD_REG_AR      4'h8
`define LIRD_CTRL_RST    1'h1
`define LIRD_ST_GIM      0
`define LIRD_ST_OVM      1
`define LIRD_ST_SXM      2
`define LIRD_ST_CARRY    3
`define LIRD_ST_HALTED   4
`define LIRD_ST_EXTONLY  5
`define LIRD_ST_RPT      6
`endif

// >>> verilog/lird_rpt_counter.v
// repeat counter: loads a count and steps down once per repeated run
`timescale 1ns/100ps
`default_nettype none
module lird_rpt_counter #(
	parameter W = 16
) (
	input  wire         clk_sys,
	input  wire         reset_n,
	input  wire         load,
	input  wire [W-1:0] load_val,
	input  wire         dec,
	output wire [W-1:0] count,
	output wire         busy
);
	reg [W-1:0] cnt_q;

	// count down per run; busy drops at zero so fetch resumes
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			cnt_q <= {W{1'b0}};
		end else if (load) begin
			cnt_q <= load_val; // full width counter
		end else if (dec) begin
			cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
		end
	end

	assign count = cnt_q;
	assign busy  = |cnt_q;
endmodule
`default_nettype wire

// >>> verilog/lird_core.v
// decode and control core: idle, repeat, bit ops and folded legacy forms
//
// Decided for this implementation: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none
`include "lird_defines.vh"
module lird_core #(
	parameter NUM_INT      = 4,
	parameter EXT_INT_MASK = 4'hC
) (
	input  wire                clk_sys,
	input  wire                reset_n,
	input  wire [5:0]          avs_address,
	input  wire                avs_read,
	input  wire                avs_write,
	input  wire [31:0]         avs_writedata,
	output wire [31:0]         avs_readdata,
	output wire                avs_waitrequest,
	output wire [15:0]         pm_addr,
	output wire                pm_rd,
	input  wire [15:0]         pm_data,
	input  wire [NUM_INT-1:0]  int_req,
	output wire                int_ack,
	output wire [3:0]          int_id,
	output wire                halted
);
	// -----------------------------------------------------------------
	// states, one-hot
	// -----------------------------------------------------------------
	localparam [6:0] S_FETCH = 7'h01;
	localparam [6:0] S_DEC   = 7'h02;
	localparam [6:0] S_OPF   = 7'h04;
	localparam [6:0] S_OPD   = 7'h08;
	localparam [6:0] S_EXEC  = 7'h10;
	localparam [6:0] S_HALT  = 7'h20;
	localparam [6:0] S_FLUSH = 7'h40;
	reg  [6:0]  st_q;
	reg  [15:0] pc_q, ir_q, opnd_q, stack_q, pm_addr_q;
	reg         pm_rd_q, int_ack_q;
	reg  [3:0]  int_id_q;
	reg  [31:0] acc_q;
	reg         carry_q, gim_q, ovm_q, sxm_q, ext_only_q;
	reg  [8:0]  dp_q;
	reg  [2:0]  arp_q;
	reg  [1:0]  flush_q, normalize_op_cnt_q;
	reg  [15:0] spc_q;
	reg  [15:0] ar_q [0:7];
	reg  [15:0] dmem_q [0:15];
	reg         wait_q, run_q;
	reg  [NUM_INT-1:0] imr_q;
	reg  [31:0] rdata_q;
	integer     i, k;
	// -----------------------------------------------------------------
	// decode helpers
	// -----------------------------------------------------------------
	wire [3:0]  op      = ir_q[15:12];
	wire [3:0]  pm_op   = pm_data[15:12];
	wire        two_word = (pm_op == `LIRD_OP_RPT_L) ||
	                       (pm_op == `LIRD_OP_ADD_L) ||
	                       (pm_op == `LIRD_OP_OPL) ||
	                       (pm_op == `LIRD_OP_APL) ||
	                       (pm_op == `LIRD_OP_XPL) ||
	                       (pm_op == `LIRD_OP_CONDITIONAL_BRANCH_OP);
	// control register reachable by instructions only on data page zero
	wire        spc_hit = (dp_q == 9'h000) &&
	                      (ir_q[6:0] == `LIRD_SPC_DADDR);
	wire        dm_hit  = (dp_q == 9'h000) &&
	                      (ir_q[6:4] == `LIRD_DMEM_OFS);
	wire [15:0] mem_rd  = spc_hit ? spc_q :
	                      (dm_hit ? dmem_q[ir_q[3:0]] : 16'h0000);
	wire        in_exec = (st_q == S_EXEC);
	// repeat counter hookup; a running repeat blocks reloading
	wire        rpt_busy;
	wire [15:0] rpt_count;
	wire        rpt_op  = (op == `LIRD_OP_RPT_K) ||
	                      (op == `LIRD_OP_RPT_L) ||
	                      (op == `LIRD_OP_RPT_M);
	wire        rpt_load = in_exec && rpt_op && !rpt_busy;
	wire        rpt_dec  = in_exec && rpt_busy;
	// short, long (second word) or data memory count
	wire [15:0] rpt_val = (op == `LIRD_OP_RPT_K) ? {8'h00, ir_q[7:0]} :
	                      ((op == `LIRD_OP_RPT_L) ? opnd_q : mem_rd);
	lird_rpt_counter #(.W(16)) u_rpt (
		.clk_sys  (clk_sys),
		.reset_n  (reset_n),
		.load     (rpt_load),
		.load_val (rpt_val),
		.dec      (rpt_dec),
		.count    (rpt_count),
		.busy     (rpt_busy)
	);
	// -----------------------------------------------------------------
	// add operand folding and condition test
	// -----------------------------------------------------------------
	reg  [31:0] add_opnd;
	reg         cond_ok;
	// one add, format picks short, long or high-half operand
	always @* begin
		case (op)
		`LIRD_OP_ADD_K: add_opnd = {24'h000000, ir_q[7:0]};
		`LIRD_OP_ADD_L: add_opnd = {16'h0000, opnd_q};
		default: begin
			if (ir_q[`LIRD_F_SHIFT16])
				add_opnd = {mem_rd, 16'h0000};
			else if (sxm_q)
				add_opnd = {{16{mem_rd[15]}}, mem_rd};
			else
				add_opnd = {16'h0000, mem_rd};
		end
		endcase
	end
	wire [32:0] add_sum = {1'b0, acc_q} + {1'b0, add_opnd};
	// legacy branch family folded into one conditional branch
	always @* begin
		case (ir_q[11:8])
		`LIRD_CC_ALWAYS: cond_ok = 1'b1;
		`LIRD_CC_EQ:     cond_ok = (acc_q == 32'h00000000);
		`LIRD_CC_NEQ:    cond_ok = (acc_q != 32'h00000000);
		`LIRD_CC_LT:     cond_ok = acc_q[31];
		`LIRD_CC_GT:     cond_ok = !acc_q[31] && (|acc_q);
		`LIRD_CC_GEQ:    cond_ok = !acc_q[31];
		`LIRD_CC_LEQ:    cond_ok = acc_q[31] || !(|acc_q);
		`LIRD_CC_C:      cond_ok = carry_q;
		`LIRD_CC_NC:     cond_ok = !carry_q;
		default:         cond_ok = 1'b0;
		endcase
	end
	// -----------------------------------------------------------------
	// interrupt priority: lowest pending index wins
	// -----------------------------------------------------------------
	wire [NUM_INT-1:0] pend     = int_req & imr_q;
	wire [NUM_INT-1:0] ext_mask = EXT_INT_MASK[NUM_INT-1:0];
	reg  [3:0] int_sel;
	always @* begin
		int_sel = 4'h0;
		for (k = NUM_INT - 1; k >= 0; k = k - 1) begin
			if (pend[k])
				int_sel = k[3:0];
		end
	end
	// taken only with the mask clear and no repeat in flight
	wire int_go = (|pend) && !gim_q && !rpt_busy;
	// second idle listens to external sources only
	wire wake   = ext_only_q ? (|(pend & ext_mask)) : (|pend);
	wire [2:0] arp_next = (op == `LIRD_OP_NORMALIZE_OP && ir_q[`LIRD_F_ALT]) ?
	                      ir_q[2:0] : arp_q;
	wire [15:0] rmw_val = (op == `LIRD_OP_OPL) ? (mem_rd | opnd_q) :
	                      ((op == `LIRD_OP_APL) ? (mem_rd & opnd_q) :
	                      (mem_rd ^ opnd_q));
	wire bus_wr   = avs_write && !wait_q;
	// -----------------------------------------------------------------
	// core sequencer
	// -----------------------------------------------------------------
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			st_q       <= S_FETCH;
			pc_q       <= `LIRD_RESET_PC;
			ir_q       <= 16'h0000;
			opnd_q     <= 16'h0000;
			stack_q    <= 16'h0000;
			pm_addr_q  <= 16'h0000;
			pm_rd_q    <= 1'b0;
			int_ack_q  <= 1'b0;
			int_id_q   <= 4'h0;
			acc_q      <= 32'h00000000;
			carry_q    <= 1'b0;
			gim_q      <= 1'b1;
			ovm_q      <= 1'b0;
			sxm_q      <= 1'b0;
			ext_only_q <= 1'b0;
			dp_q       <= 9'h000;
			arp_q      <= 3'h0;
			flush_q    <= 2'h0;
			normalize_op_cnt_q <= 2'h0;
			spc_q      <= `LIRD_SPC_RST;
			for (i = 0; i < 8; i = i + 1)
				ar_q[i] <= 16'h0000;
			for (i = 0; i < 16; i = i + 1)
				dmem_q[i] <= 16'h0000;
		end else begin
			int_ack_q <= 1'b0;
			case (st_q)
			S_FETCH: begin
				if (int_go) begin
					// vector: save return, mask further, flush
					stack_q   <= pc_q;
					pc_q      <= `LIRD_VEC_BASE + {11'h000, int_sel, 1'b0};
					gim_q     <= 1'b1;
					int_ack_q <= 1'b1;
					int_id_q  <= int_sel;
					flush_q   <= `LIRD_DISC_FLUSH;
					st_q      <= S_FLUSH;
				end else if (run_q) begin
					pm_rd_q   <= 1'b1;
					pm_addr_q <= pc_q;
					st_q      <= S_DEC;
				end
			end
			S_DEC: begin
				pm_rd_q <= 1'b0;
				ir_q    <= pm_data;
				pc_q    <= pc_q + 16'h0001;
				// long forms pull a second word first
				st_q    <= two_word ? S_OPF : S_EXEC;
			end
			S_OPF: begin
				pm_rd_q   <= 1'b1;
				pm_addr_q <= pc_q;
				st_q      <= S_OPD;
			end
			S_OPD: begin
				pm_rd_q <= 1'b0;
				opnd_q  <= pm_data;
				pc_q    <= pc_q + 16'h0001;
				st_q    <= S_EXEC;
			end
			S_EXEC: begin
				// stay here while repeats remain, refetch at zero
				if (!rpt_busy)
					st_q <= S_FETCH;
				// deferred normalize write lands on the next pointer (arp_next), a same-cycle load included
				if (normalize_op_cnt_q != 2'h0) begin
					normalize_op_cnt_q <= normalize_op_cnt_q - 2'h1;
					if (normalize_op_cnt_q == 2'h1)
						ar_q[arp_next] <= ar_q[arp_next] + 16'h0001;
				end
				case (op)
				`LIRD_OP_IDLE, `LIRD_OP_HALT_UNTIL_EXTERNAL_INT_OP: begin
					// halt, mask kept, pc past idle
					ext_only_q <= (op == `LIRD_OP_HALT_UNTIL_EXTERNAL_INT_OP);
					st_q       <= S_HALT;
				end
				`LIRD_OP_ADD_K, `LIRD_OP_ADD_L, `LIRD_OP_ADD_M: begin
					{carry_q, acc_q} <= add_sum;
				end
				`LIRD_OP_OPL, `LIRD_OP_APL, `LIRD_OP_XPL: begin
					// read-modify-write, others keep value
					if (spc_hit)
						spc_q <= rmw_val; // serial mode bits 2, 3, 5
					else if (dm_hit)
						dmem_q[ir_q[3:0]] <= rmw_val;
				end
				`LIRD_OP_LDP: begin
					if (ir_q[`LIRD_F_ALT]) begin
						pc_q    <= stack_q;
						flush_q <= `LIRD_DISC_FLUSH;
						st_q    <= S_FLUSH;
					end else begin
						dp_q <= ir_q[8:0];
					end
				end
				`LIRD_OP_CONDITIONAL_BRANCH_OP: begin
					if (cond_ok) begin
						pc_q    <= opnd_q;
						// delayed form costs two cycles, else four
						flush_q <= ir_q[`LIRD_F_DELAYED] ?
						           `LIRD_DLY_FLUSH : `LIRD_DISC_FLUSH;
						st_q    <= S_FLUSH;
					end
				end
				`LIRD_OP_CTRLBIT: begin
					// set/clear forms, no serial bits here
					case (ir_q[1:0])
					`LIRD_CB_GIM:   gim_q   <= ir_q[`LIRD_F_SETBIT];
					`LIRD_CB_OVM:   ovm_q   <= ir_q[`LIRD_F_SETBIT];
					`LIRD_CB_SXM:   sxm_q   <= ir_q[`LIRD_F_SETBIT];
					default:        carry_q <= ir_q[`LIRD_F_SETBIT];
					endcase
				end
				`LIRD_OP_NORMALIZE_OP: begin
					if (ir_q[`LIRD_F_ALT]) begin
						arp_q <= ir_q[2:0];
					end else if ((acc_q[31] == acc_q[30]) && (|acc_q)) begin
						acc_q      <= {acc_q[30:0], 1'b0};
						normalize_op_cnt_q <= `LIRD_NORMALIZE_OP_LAG;
					end
				end
				default: ;
				endcase
			end
			S_HALT: begin
				// to fetch: mask set runs on, clear vectors
				if (wake)
					st_q <= S_FETCH;
			end
			S_FLUSH: begin
				if (flush_q == 2'h0)
					st_q <= S_FETCH;
				else
					flush_q <= flush_q - 2'h1;
			end
			default: st_q <= S_FETCH;
			endcase
			// bus write to the control register wins a same-cycle clash
			if (bus_wr && avs_address[5:2] == `LIRD_REG_SPC)
				spc_q <= avs_writedata[15:0];
		end
	end
	// -----------------------------------------------------------------
	// avalon slave: one wait cycle, answer on the second
	// -----------------------------------------------------------------
	// registered waitrequest: glitch free, one wait cycle per access
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			wait_q  <= 1'b1;
			run_q   <= `LIRD_CTRL_RST;
			imr_q   <= {NUM_INT{1'b0}};
			rdata_q <= 32'h00000000;
		end else begin
			wait_q <= !((avs_read || avs_write) && wait_q);
			if (bus_wr && avs_address[5:2] == `LIRD_REG_CTRL)
				run_q <= avs_writedata[0];
			if (bus_wr && avs_address[5:2] == `LIRD_REG_IMR)
				imr_q <= avs_writedata[NUM_INT-1:0];
			if (avs_read && wait_q) begin
				case (avs_address[5:2])
				`LIRD_REG_CTRL:   rdata_q <= {31'h0, run_q};
				`LIRD_REG_IMR:    rdata_q <= {{(32-NUM_INT){1'b0}}, imr_q};
				`LIRD_REG_SPC:    rdata_q <= {16'h0000, spc_q};
				`LIRD_REG_STATUS: rdata_q <= {25'h0, rpt_busy, ext_only_q,
				                  (st_q == S_HALT), carry_q, sxm_q, ovm_q,
				                  gim_q};
				`LIRD_REG_PC:     rdata_q <= {16'h0000, pc_q};
				`LIRD_REG_RPT:    rdata_q <= {16'h0000, rpt_count};
				`LIRD_REG_ACC_LO: rdata_q <= {16'h0000, acc_q[15:0]};
				`LIRD_REG_ACC_HI: rdata_q <= {16'h0000, acc_q[31:16]};
				`LIRD_REG_AR:     rdata_q <= {16'h0000, ar_q[arp_q]};
				default:          rdata_q <= 32'h00000000;
				endcase
			end
		end
	end
	assign avs_readdata    = rdata_q;
	assign avs_waitrequest = wait_q;
	assign pm_addr         = pm_addr_q;
	assign pm_rd           = pm_rd_q;
	assign int_ack         = int_ack_q;
	assign int_id          = int_id_q;
	assign halted          = st_q[5];
endmodule
`default_nettype wire

// >>> sim/lird_core_checker.sv
// assertion checker bound to the ports of the decode core
`timescale 1ns/100ps
`default_nettype none
`include "lird_defines.vh"
module lird_core_checker #(
	parameter NUM_INT      = 4,
	parameter EXT_INT_MASK = 4'hC
) (
	input wire logic               clk_sys,
	input wire logic               reset_n,
	input wire logic               avs_read,
	input wire logic               avs_write,
	input wire logic               avs_waitrequest,
	input wire logic [15:0]        pm_addr,
	input wire logic               pm_rd,
	input wire logic [NUM_INT-1:0] int_req,
	input wire logic               int_ack,
	input wire logic [3:0]         int_id,
	input wire logic               halted
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);
	// -----------------------------------------------------------------
	// interrupt and fetch steps
	// -----------------------------------------------------------------
	// vector fetch lands after the flush, base plus two words per index
	sequence s_vec_fetch;
		##4 (pm_rd && pm_addr == `LIRD_VEC_BASE + {11'h000, int_id, 1'b0});
	endsequence
	sequence s_ack_seen;
		int_ack && !halted && int_req[int_id];
	endsequence
	a_halt_no_fetch: assert property (halted && $past(halted) |-> !pm_rd)
		else $error("fetch issued while halted");
	a_wake_has_cause: assert property ($fell(halted) |-> $past(int_req) != 0)
		else $error("halt ended with no request");
	a_ack_from_req: assert property (int_ack |-> s_ack_seen)
		else $error("ack without pending request");
	a_vector_fetch: assert property (int_ack |-> s_vec_fetch)
		else $error("vector fetch missing or late");
	a_ack_one_pulse: assert property (int_ack |=> !int_ack)
		else $error("ack longer than one cycle");
	a_fetch_gap: assert property (pm_rd |=> !pm_rd)
		else $error("fetch reads back to back");
	// -----------------------------------------------------------------
	// register bus handshake
	// -----------------------------------------------------------------
	a_bus_one_wait: assert property
		((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus answer not after one wait");
	a_bus_answer_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low too long");
	a_bus_answer_cause: assert property
		($fell(avs_waitrequest) |-> $past(avs_read || avs_write))
		else $error("answer without request");
endmodule
bind lird_core lird_core_checker #(
	.NUM_INT      (NUM_INT),
	.EXT_INT_MASK (EXT_INT_MASK)
) u_chk (
	.clk_sys         (clk_sys),
	.reset_n         (reset_n),
	.avs_read        (avs_read),
	.avs_write       (avs_write),
	.avs_waitrequest (avs_waitrequest),
	.pm_addr         (pm_addr),
	.pm_rd           (pm_rd),
	.int_req         (int_req),
	.int_ack         (int_ack),
	.int_id          (int_id),
	.halted          (halted)
);
`default_nettype wire

// >>> sim/lird_pm_model.sv
// program memory and interrupt sources facing the decode core
`timescale 1ns/100ps
`default_nettype none
module lird_pm_model #(
	parameter NUM_INT = 4
) (
	input  wire logic               clk_sys,
	input  wire logic               reset_n,
	input  wire logic [15:0]        pm_addr,
	input  wire logic               pm_rd,
	output var  logic [15:0]        pm_data,
	input  wire logic               int_ack,
	input  wire logic [3:0]         int_id,
	output var  logic [NUM_INT-1:0] int_req
);
	logic [15:0] rom [0:255];
	logic [15:0] junk_q;
	initial int_req = '0;
	// -----------------------------------------------------------------
	// memory and sources
	// -----------------------------------------------------------------
	// the core takes the word at the edge that ends its read cycle, so the
	// array answers the registered address at once; outside a read the
	// bus toggles so stale data never passes
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			junk_q <= 16'hA5A5;
		else
			junk_q <= ~junk_q;
	end
	always_comb pm_data = pm_rd ? rom[pm_addr[7:0]] : junk_q;
	// a source holds its level until the core acknowledges it or drop clears it
	always @(posedge clk_sys) begin
		if (int_ack)
			int_req[int_id] <= 1'b0;
	end
	task raise(input int i);
		int_req[i] <= 1'b1;
	endtask
	task drop(input int i);
		int_req[i] <= 1'b0;
	endtask
endmodule
`default_nettype wire

// >>> sim/test_legacy_compatible_idle_repeat_decode.sv
// self-checking bench for the idle, repeat and bit-op decode core
`timescale 1ns/100ps
`default_nettype none
`include "lird_defines.vh"
module test_legacy_compatible_idle_repeat_decode;
	logic        clk_sys;
	logic        reset_n;
	logic [5:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	wire  [31:0] avs_readdata;
	wire         avs_waitrequest;
	wire  [15:0] pm_addr;
	wire         pm_rd;
	wire  [15:0] pm_data;
	wire  [3:0]  int_req;
	wire         int_ack;
	wire  [3:0]  int_id;
	wire         halted;
	int          bad_count = 0;
	int          checks = 0;
	int          ack_n = 0;
	logic [3:0]  ack_id;
	logic [31:0] rd;
	logic [31:0] acc0;
	localparam logic [15:0] ALL3 = `LIRD_SPC_FMT | `LIRD_SPC_FSM | `LIRD_SPC_TXM;
	// program image, address in the upper half; vector 2 sits at 0x06
	logic [31:0] img [$] = '{32'h0000D000, 32'h00010010, 32'h00066010,
		32'h0007C800, 32'h0010C000, // page zero first
		32'h00119022, 32'h0012012C, 32'h0013A022, 32'h0014FFF7,
		32'h0015B022, 32'h0016000C, 32'h00171000, 32'h00184000,
		32'h00190003, 32'h001A6001, 32'h001B7000, 32'h001C0100,
		32'h001DE000, 32'h001E2000, 32'h001F1000,
		32'h0020F000, 32'h0021F803, 32'h00220000, 32'h00231000};
	lird_core DUT (
		.clk_sys         (clk_sys),
		.reset_n         (reset_n),
		.avs_address     (avs_address),
		.avs_read        (avs_read),
		.avs_write       (avs_write),
		.avs_writedata   (avs_writedata),
		.avs_readdata    (avs_readdata),
		.avs_waitrequest (avs_waitrequest),
		.pm_addr         (pm_addr),
		.pm_rd           (pm_rd),
		.pm_data         (pm_data),
		.int_req         (int_req),
		.int_ack         (int_ack),
		.int_id          (int_id),
		.halted          (halted)
	);
	lird_pm_model u_pm (
		.clk_sys (clk_sys),
		.reset_n (reset_n),
		.pm_addr (pm_addr),
		.pm_rd   (pm_rd),
		.pm_data (pm_data),
		.int_ack (int_ack),
		.int_id  (int_id),
		.int_req (int_req)
	);
	// -----------------------------------------------------------------
	// helpers
	// -----------------------------------------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	// ack pulses are counted so a missing or extra vector is seen
	always @(posedge clk_sys) begin
		if (int_ack === 1'b1) begin
			ack_n++;
			ack_id = int_id;
		end
	end
	task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// one bus access; request held until waitrequest is sampled low
	task bus(input logic wr, input logic [3:0] r, input logic [31:0] wd);
		int n;
		n = 0;
		avs_address   <= {r, 2'b00};
		avs_writedata <= wd;
		avs_write     <= wr;
		avs_read      <= !wr;
		do begin
			@(posedge clk_sys);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		if (n >= 50)
			bad_count++;
		rd = avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk_sys);
	endtask
	task wait_halt(input logic lvl);
		int n;
		n = 0;
		while (halted !== lvl && n < 200) begin
			@(posedge clk_sys);
			n++;
		end
		check("halted", halted, lvl);
	endtask
	task finish_test;
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// -----------------------------------------------------------------
	// scenarios
	// -----------------------------------------------------------------
	task sc_reset;
		bus(1'b0, `LIRD_REG_IMR, 32'h0);
		check("imr", rd, 32'h0);
		bus(1'b1, 4'h9, 32'hFFFF);
		bus(1'b0, 4'h9, 32'h0);
		check("unmapped", rd, 32'h0);
	endtask
	// or, and, xor on the serial control word; halt with interrupts off
	task sc_bit_ops;
		wait_halt(1'b1);
		bus(1'b0, `LIRD_REG_SPC, 32'h0);
		check("serial", rd, {16'h0, ((16'h0100 | ALL3) & ~`LIRD_SPC_FSM)
			^ (`LIRD_SPC_FMT | `LIRD_SPC_FSM)});
		bus(1'b0, `LIRD_REG_STATUS, 32'h0);
		check("status", rd & 32'h51, 32'h11);
		bus(1'b0, `LIRD_REG_PC, 32'h0);
		check("pc", rd, 32'h18);
		bus(1'b0, `LIRD_REG_ACC_LO, 32'h0);
		acc0 = rd;
	endtask
	// masked wake resumes in line, then repeat and long add run
	task sc_wake_masked;
		bus(1'b1, `LIRD_REG_IMR, 32'h5);
		u_pm.raise(0);
		wait_halt(1'b0);
		u_pm.drop(0);
		wait_halt(1'b1);
		check("acks", ack_n, 0);
		bus(1'b0, `LIRD_REG_ACC_LO, 32'h0);
		check("acc", rd, acc0 + 32'h0104);
		bus(1'b0, `LIRD_REG_RPT, 32'h0);
		check("rpt", rd, 32'h0);
		bus(1'b0, `LIRD_REG_STATUS, 32'h0);
		check("status", rd & 32'h41, 32'h0);
		bus(1'b0, `LIRD_REG_PC, 32'h0);
		check("pc", rd, 32'h1F);
	endtask
	// second halt ignores an internal source, vectors on an external one
	task sc_ext_only;
		u_pm.raise(0);
		repeat (20) @(posedge clk_sys);
		check("halted", halted, 1'b1);
		check("acks", ack_n, 0);
		u_pm.drop(0);
		u_pm.raise(2);
		wait_halt(1'b0);
		wait_halt(1'b1);
		check("acks", ack_n, 1);
		check("ack_id", ack_id, 4'h2);
		bus(1'b0, `LIRD_REG_ACC_LO, 32'h0);
		check("acc", rd, acc0 + 32'h0114);
		bus(1'b0, `LIRD_REG_PC, 32'h0);
		check("pc", rd, 32'h20);
	endtask
	// masked wake runs normalize; its late update lands on the new pointer
	task sc_normalize_op;
		u_pm.raise(0);
		wait_halt(1'b0);
		u_pm.drop(0);
		wait_halt(1'b1);
		check("acks", ack_n, 1);
		bus(1'b0, `LIRD_REG_AR, 32'h0);
		check("ar", rd, 32'h1);
		bus(1'b0, `LIRD_REG_ACC_LO, 32'h0);
		check("acc", rd, (acc0 + 32'h0114) << 1);
	endtask
	initial begin
		reset_n       = 1'b0;
		avs_address   = 6'h00;
		avs_read      = 1'b0;
		avs_write     = 1'b0;
		avs_writedata = 32'h0;
		for (int i = 0; i < 256; i++)
			u_pm.rom[i] = 16'h0000;
		foreach (img[i])
			u_pm.rom[img[i][23:16]] = img[i][15:0];
		repeat (3) @(posedge clk_sys);
		reset_n <= 1'b1;
		@(posedge clk_sys);
		sc_reset;
		sc_bit_ops;
		sc_wake_masked;
		sc_ext_only;
		sc_normalize_op;
		finish_test;
	end
	// watchdog well beyond the few hundred cycles the run needs
	initial begin
		repeat (5000) @(posedge clk_sys);
		bad_count++;
		finish_test;
	end
endmodule
`default_nettype wire
